// ---- mawm_map.vh ----
// Constants for the motor alarm and warning manager
//
// Contract
// (RULE1) Thermal protector open raises overheat alarm
// (RULE2) Shaft locked past set time raises lock alarm
// (RULE3) Speed above 2300 r/min raises overspeed alarm
// (RULE4) Speed above 2100 r/min drives brake current
// (RULE5) Store failure alarm ignores fault-clear input
// (RULE6) Run input at power-up alarms, self-clears later
// (RULE7) Power-on run alarm can be disabled, default on
// (RULE8) Assigned external fault input low raises stop alarm
// (RULE9) Fault-clear acts on rising edge only
// (RULE10) Fault-clear ignored while any run input active
// (RULE11) Panel reset and power cycle also clear alarms
// (RULE12) Host drops run inputs before any reset
// (RULE13) Keep nine-entry alarm history, newest first
// (RULE14) History clear erases; display blinks meanwhile
// (RULE15) Any warning drives caution output, unmapped by default
// (RULE16) Warning history volatile, lost at power-off
// (RULE17) Lock of one second raises non-stop warning
// (RULE18) Run function mapped onto active terminal: warn, stop
// (RULE19) Leaving test after inching with run active: warn, stop
// (RULE20) Alarm: coast, fault output low, lamp, code shown
// (RULE21) Warning output drops when its cause clears
// (RULE22) Alarms latch until reset, power-on alarm self-clears
`ifndef MAWM_MAP_VH
`define MAWM_MAP_VH
// Alarm codes, shown as two hexadecimal digits
`define MAWM_AL_NONE 8'h00
`define MAWM_AL_OVERHEAT 8'h25
`define MAWM_AL_LOCK 8'h28
`define MAWM_AL_OVERSPEED 8'h31
`define MAWM_AL_STORE 8'h41
`define MAWM_AL_POWERON 8'h45
`define MAWM_AL_EXTSTOP 8'h6e
// Warning codes
`define MAWM_WN_LOCK 8'h30
`define MAWM_WN_OPERR 8'h6f
// Speed thresholds in r/min
`define MAWM_SPEED_ALARM 12'd2300
`define MAWM_SPEED_BRAKE 12'd2100
// Lock warning time and cycle count at 40 MHz
`define MAWM_CLK_HZ 40000000
`define MAWM_LOCK_WARN_MS 1000
`define MAWM_LOCK_WARN_CYC ((`MAWM_CLK_HZ / 1000) * `MAWM_LOCK_WARN_MS)
// History depth and erase duration in cycles per entry
`define MAWM_HIST_DEPTH 9
`define MAWM_ERASE_CYC 16'd40000
`endif

// ---- mawm_history.v ----
// Nine-entry alarm history shift store with timed erase
`timescale 1ns/100ps
`default_nettype none
`include "mawm_map.vh"
module mawm_history (
   input wire clock,
   input wire srst,
   input wire push,
   input wire [7:0] code_in,
   input wire erase_req,
   input wire [3:0] read_index,
   output reg [7:0] read_code,
   output reg erasing
);
   reg [7:0] entry [0:`MAWM_HIST_DEPTH-1];
   reg [15:0] erase_cnt;
   reg [3:0] erase_pos;
   integer i;

   // Newest at index 0; push shifts older ones down, oldest falls off
   always @(posedge clock) begin
      if (srst) begin
         erasing <= 1'b0;
         erase_cnt <= 16'h0000;
         erase_pos <= 4'h0;
         read_code <= 8'h00;
      end else begin
         read_code <= (read_index < `MAWM_HIST_DEPTH) ? entry[read_index] : 8'h00; // RULE13
         if (erasing) begin
            // Slow erase models a store write per entry; display blinks meanwhile
            if (erase_cnt == `MAWM_ERASE_CYC - 16'h0001) begin
               erase_cnt <= 16'h0000;
               entry[erase_pos] <= `MAWM_AL_NONE; // RULE14
               if (erase_pos == `MAWM_HIST_DEPTH - 1)
                  erasing <= 1'b0; // RULE14
               else
                  erase_pos <= erase_pos + 4'h1;
            end else begin
               erase_cnt <= erase_cnt + 16'h0001;
            end
         end else if (erase_req) begin
            erasing <= 1'b1; // RULE14
            erase_pos <= 4'h0;
            erase_cnt <= 16'h0000;
         end else if (push) begin
            for (i = `MAWM_HIST_DEPTH - 1; i > 0; i = i - 1)
               entry[i] <= entry[i-1]; // RULE13
            entry[0] <= code_in;
         end
      end
   end
endmodule // mawm_history
`default_nettype wire

// ---- mawm_top.v ----
// Motor alarm and warning manager top level
`timescale 1ns/100ps
`default_nettype none
`include "mawm_map.vh"
module mawm_top #(
   parameter [31:0] LOCK_WARN_CYC = `MAWM_LOCK_WARN_CYC
) (
   input wire CLOCK,
   input wire SRST,
   input wire THERMAL_OPEN,
   input wire SHAFT_LOCKED,
   input wire [11:0] SHAFT_SPEED,
   input wire [31:0] LOCK_ALARM_CYC,
   input wire STORE_FAIL,
   input wire FORWARD_RUN_INPUT,
   input wire REVERSE_RUN_INPUT,
   input wire POWERON_ALARM_ENABLE,
   input wire EXT_FAULT_ASSIGNED,
   input wire EXTERNAL_FAULT_INPUT,
   input wire FAULT_CLEAR,
   input wire PANEL_RESET,
   input wire HIST_CLEAR,
   input wire [3:0] HIST_INDEX,
   input wire RUN_MAP_WRITE,
   input wire RUN_MAP_TERM_ACTIVE,
   input wire TEST_MODE,
   input wire INCHING_RUN,
   input wire CAUTION_ASSIGNED,
   input wire CAUTION_CLEAR,
   output reg ALARM_OUT,
   output reg ALARM_LED,
   output reg [7:0] ALARM_CODE,
   output reg MOTOR_COAST,
   output reg MOTOR_STOP,
   output reg BRAKE_CURRENT,
   output reg THERMAL_OPEN_OUTPUT,
   output reg CAUTION_OUTPUT,
   output reg CAUTION_TERMINAL,
   output reg [7:0] CAUTION_CODE,
   output reg [7:0] HIST_CODE,
   output reg DISPLAY_BLINK
);
   // Alarm state, one-hot
   localparam [2:0] ST_POWERUP = 3'b001;
   localparam [2:0] ST_NORMAL = 3'b010;
   localparam [2:0] ST_ALARM = 3'b100;

   reg [2:0] state;
   reg [7:0] code;
   reg [31:0] lock_cnt;
   reg fault_clear_d;
   reg test_d;
   reg inched;
   reg operr;
   reg push;
   reg [7:0] push_code;
   reg [7:0] next_code;
   wire run_any;
   wire clear_edge;
   wire panel_ok;
   wire lock_warn;
   wire [7:0] hist_code;
   wire hist_busy;

   // Ranks new alarm causes; store failure outranks the rest
   function [7:0] mawm_cause;
      input store, therm, over, lockd, ext;
      begin
         if (store)
            mawm_cause = `MAWM_AL_STORE;
         else if (therm)
            mawm_cause = `MAWM_AL_OVERHEAT;
         else if (over)
            mawm_cause = `MAWM_AL_OVERSPEED;
         else if (lockd)
            mawm_cause = `MAWM_AL_LOCK;
         else if (ext)
            mawm_cause = `MAWM_AL_EXTSTOP;
         else
            mawm_cause = `MAWM_AL_NONE;
      end
   endfunction

   assign run_any = FORWARD_RUN_INPUT | REVERSE_RUN_INPUT;
   // Edge only, and never while a run input is on
   assign clear_edge = FAULT_CLEAR & ~fault_clear_d & ~run_any; // RULE9 RULE10
   // Host is expected to drop the run inputs first; panel reset obeys too
   assign panel_ok = PANEL_RESET & ~run_any;
   assign lock_warn = SHAFT_LOCKED && (lock_cnt >= LOCK_WARN_CYC); // RULE17

   // Lock duration counter, saturating so it never wraps back to zero
   always @(posedge CLOCK) begin
      if (SRST)
         lock_cnt <= 32'h00000000;
      else if (!SHAFT_LOCKED)
         lock_cnt <= 32'h00000000;
      else if (lock_cnt != 32'hffffffff)
         lock_cnt <= lock_cnt + 32'h00000001;
   end

   // Next alarm code from the current state and causes
   always @* begin
      next_code = code;
      case (state)
         ST_POWERUP: begin
            if (POWERON_ALARM_ENABLE && run_any) // RULE6 RULE7
               next_code = `MAWM_AL_POWERON;
            else
               next_code = mawm_cause(STORE_FAIL, THERMAL_OPEN, SHAFT_SPEED > `MAWM_SPEED_ALARM,
                  SHAFT_LOCKED && (lock_cnt > LOCK_ALARM_CYC), EXT_FAULT_ASSIGNED & ~EXTERNAL_FAULT_INPUT);
         end
         ST_NORMAL: begin
            next_code = mawm_cause(STORE_FAIL, THERMAL_OPEN, // RULE1
               SHAFT_SPEED > `MAWM_SPEED_ALARM, // RULE3
               SHAFT_LOCKED && (lock_cnt > LOCK_ALARM_CYC), // RULE2
               EXT_FAULT_ASSIGNED & ~EXTERNAL_FAULT_INPUT); // RULE8
         end
         ST_ALARM: begin
            if (code == `MAWM_AL_POWERON) begin
               if (!run_any)
                  next_code = `MAWM_AL_NONE; // RULE6 RULE22
            end else if (code == `MAWM_AL_STORE) begin
               if (panel_ok)
                  next_code = `MAWM_AL_NONE; // RULE5 RULE11
            end else if (clear_edge || panel_ok) begin
               next_code = `MAWM_AL_NONE; // RULE9 RULE11 RULE22
            end
         end
         default: next_code = `MAWM_AL_NONE;
      endcase
   end

   // Alarm latch; a synchronous reset stands in for a control power cycle
   always @(posedge CLOCK) begin
      if (SRST) begin
         state <= ST_POWERUP; // RULE11
         code <= `MAWM_AL_NONE;
         fault_clear_d <= 1'b0;
         push <= 1'b0;
         push_code <= 8'h00;
      end else begin
         fault_clear_d <= FAULT_CLEAR;
         push <= 1'b0;
         code <= next_code;
         case (state)
            ST_POWERUP: begin
               if (next_code != `MAWM_AL_NONE) begin
                  state <= ST_ALARM;
                  push <= 1'b1;
                  push_code <= next_code;
               end else begin
                  state <= ST_NORMAL;
               end
            end
            ST_NORMAL: begin
               if (next_code != `MAWM_AL_NONE) begin
                  state <= ST_ALARM; // RULE22
                  push <= 1'b1; // RULE13
                  push_code <= next_code;
               end
            end
            ST_ALARM: begin
               if (next_code == `MAWM_AL_NONE)
                  state <= ST_NORMAL;
            end
            default: state <= ST_NORMAL;
         endcase
      end
   end

   // Operation error: run remap onto a live terminal, or leaving test after inching
   always @(posedge CLOCK) begin
      if (SRST) begin
         test_d <= 1'b0;
         inched <= 1'b0;
         operr <= 1'b0;
      end else begin
         test_d <= TEST_MODE;
         if (!TEST_MODE)
            inched <= 1'b0;
         else if (INCHING_RUN)
            inched <= 1'b1;
         if (RUN_MAP_WRITE && RUN_MAP_TERM_ACTIVE)
            operr <= 1'b1; // RULE18
         else if (test_d && !TEST_MODE && inched && run_any)
            operr <= 1'b1; // RULE19
         else if (!run_any)
            operr <= 1'b0; // RULE21
      end
   end

   // Registered outputs; caution history is plain flops, lost at power-off
   always @(posedge CLOCK) begin
      if (SRST) begin
         ALARM_OUT <= 1'b0;
         ALARM_LED <= 1'b0;
         ALARM_CODE <= 8'h00;
         MOTOR_COAST <= 1'b0;
         MOTOR_STOP <= 1'b0;
         BRAKE_CURRENT <= 1'b0;
         THERMAL_OPEN_OUTPUT <= 1'b0;
         CAUTION_OUTPUT <= 1'b0;
         CAUTION_TERMINAL <= 1'b0;
         CAUTION_CODE <= 8'h00; // RULE16
         HIST_CODE <= 8'h00;
         DISPLAY_BLINK <= 1'b0;
      end else begin
         ALARM_OUT <= (state != ST_ALARM) && (state != ST_POWERUP); // RULE20
         ALARM_LED <= (state == ST_ALARM); // RULE20
         ALARM_CODE <= code; // RULE20
         MOTOR_COAST <= (state == ST_ALARM); // RULE20
         MOTOR_STOP <= operr; // RULE18 RULE19
         BRAKE_CURRENT <= (SHAFT_SPEED > `MAWM_SPEED_BRAKE); // RULE4
         THERMAL_OPEN_OUTPUT <= THERMAL_OPEN;
         CAUTION_OUTPUT <= lock_warn | operr; // RULE15 RULE21
         // Terminal stays dark unless software assigns the caution signal
         CAUTION_TERMINAL <= CAUTION_ASSIGNED & (lock_warn | operr); // RULE15
         if (CAUTION_CLEAR)
            CAUTION_CODE <= 8'h00;
         if (operr)
            CAUTION_CODE <= `MAWM_WN_OPERR; // RULE16
         else if (lock_warn)
            CAUTION_CODE <= `MAWM_WN_LOCK; // RULE17
         HIST_CODE <= hist_code;
         DISPLAY_BLINK <= hist_busy; // RULE14
      end
   end

   mawm_history u_history (
      .clock(CLOCK),
      .srst(SRST),
      .push(push),
      .code_in(push_code),
      .erase_req(HIST_CLEAR),
      .read_index(HIST_INDEX),
      .read_code(hist_code),
      .erasing(hist_busy)
   );
endmodule // mawm_top
`default_nettype wire

// ---- mawm_checker.sv ----
// Port checker for the motor alarm and warning manager
`timescale 1ns/100ps
`default_nettype none
module mawm_checker #(
   parameter [31:0] LOCK_WARN_CYC = 32'd20
) (
   input wire logic CLOCK,
   input wire logic SRST,
   input wire logic SHAFT_LOCKED,
   input wire logic [11:0] SHAFT_SPEED,
   input wire logic THERMAL_OPEN,
   input wire logic FORWARD_RUN_INPUT,
   input wire logic REVERSE_RUN_INPUT,
   input wire logic FAULT_CLEAR,
   input wire logic PANEL_RESET,
   input wire logic HIST_CLEAR,
   input wire logic ALARM_OUT,
   input wire logic ALARM_LED,
   input wire logic [7:0] ALARM_CODE,
   input wire logic MOTOR_COAST,
   input wire logic BRAKE_CURRENT,
   input wire logic THERMAL_OPEN_OUTPUT,
   input wire logic CAUTION_OUTPUT,
   input wire logic DISPLAY_BLINK
);
   logic [31:0] lock_cnt;
   wire run = FORWARD_RUN_INPUT || REVERSE_RUN_INPUT;
   wire quiet = !PANEL_RESET && !FAULT_CLEAR;
   // Locked-cycle count; saturates so a long jam cannot wrap it
   always @(posedge CLOCK) begin
      if (SRST || !SHAFT_LOCKED)
         lock_cnt <= 32'h0;
      else if (lock_cnt != 32'hffffffff)
         lock_cnt <= lock_cnt + 32'h1;
   end
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (SRST);
   sequence s_latched;
      ALARM_LED && ALARM_CODE != 8'h45 && quiet;
   endsequence
   sequence s_blinking;
      DISPLAY_BLINK [*4];
   endsequence
   property p_therm; THERMAL_OPEN |=> THERMAL_OPEN_OUTPUT; endproperty
   a_therm: assert property (p_therm) else $error("thermal open not mirrored");
   property p_brake; SHAFT_SPEED > 12'd2100 |=> BRAKE_CURRENT; endproperty
   a_brake: assert property (p_brake) else $error("no brake current above 2100");
   property p_alarm; ALARM_LED |-> !ALARM_OUT && MOTOR_COAST && ALARM_CODE != 8'h00; endproperty
   a_alarm: assert property (p_alarm) else $error("alarm outputs disagree");
   // Clear inputs act two edges late, so a quiet sample before the latched one is needed too
   property p_latch; quiet ##1 s_latched ##1 quiet |=> ALARM_LED; endproperty
   a_latch: assert property (p_latch) else $error("alarm dropped without a reset");
   property p_store;
      !PANEL_RESET ##1 (ALARM_CODE == 8'h41 && !PANEL_RESET) ##1 !PANEL_RESET |=> ALARM_CODE == 8'h41;
   endproperty
   a_store: assert property (p_store) else $error("store alarm cleared without panel");
   property p_refuse; run ##1 (ALARM_LED && ALARM_CODE != 8'h45 && run) ##1 run |=> ALARM_LED; endproperty
   a_refuse: assert property (p_refuse) else $error("alarm cleared while running");
   property p_poweron; ALARM_CODE == 8'h45 && !run |-> ##[1:3] ALARM_CODE != 8'h45; endproperty
   a_poweron: assert property (p_poweron) else $error("power-on alarm did not self-clear");
   property p_lockwarn; lock_cnt == LOCK_WARN_CYC + 32'd4 |-> CAUTION_OUTPUT; endproperty
   a_lockwarn: assert property (p_lockwarn) else $error("lock warning missing");
   property p_blink; $rose(HIST_CLEAR) |-> ##2 s_blinking; endproperty
   a_blink: assert property (p_blink) else $error("display not blinking in erase");
endmodule // mawm_checker
`default_nettype wire

// ---- mawm_motor.sv ----
// Motor sensor model: thermal, shaft, speed and external fault lines
`timescale 1ns/100ps
`default_nettype none
module mawm_motor (
   input wire logic clock,
   input wire logic heat,
   input wire logic jam,
   input wire logic stop_open,
   input wire logic [11:0] speed_cmd,
   output logic thermal_open,
   output logic shaft_locked,
   output logic [11:0] shaft_speed,
   output logic ext_fault_n
);
   // Sensors lag the motor by one cycle; a jammed shaft reads zero speed
   always @(posedge clock) begin
      thermal_open <= heat;
      shaft_locked <= jam;
      shaft_speed <= jam ? 12'h000 : speed_cmd;
      ext_fault_n <= !stop_open; // Normally closed contact
   end
endmodule // mawm_motor
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the motor alarm and warning manager
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic CLOCK = 0, SRST = 1, STORE_FAIL = 0, FORWARD_RUN_INPUT = 0, REVERSE_RUN_INPUT = 0;
   logic POWERON_ALARM_ENABLE = 1, EXT_FAULT_ASSIGNED = 1, FAULT_CLEAR = 0, PANEL_RESET = 0, HIST_CLEAR = 0;
   logic RUN_MAP_WRITE = 0, RUN_MAP_TERM_ACTIVE = 0, TEST_MODE = 0, INCHING_RUN = 0, CAUTION_ASSIGNED = 0;
   logic CAUTION_CLEAR = 0, heat = 0, jam = 0, ext_open = 0;
   logic [3:0] HIST_INDEX = 4'h0;
   logic [11:0] speed = 12'h000;
   logic [31:0] LOCK_ALARM_CYC = 32'h28;
   logic [7:0] tab [3] = '{8'h25, 8'h31, 8'h6e};
   wire THERMAL_OPEN, SHAFT_LOCKED, EXTERNAL_FAULT_INPUT, ALARM_OUT, ALARM_LED, MOTOR_COAST, MOTOR_STOP;
   wire BRAKE_CURRENT, THERMAL_OPEN_OUTPUT, CAUTION_OUTPUT, CAUTION_TERMINAL, DISPLAY_BLINK;
   wire [11:0] SHAFT_SPEED;
   wire [7:0] ALARM_CODE, CAUTION_CODE, HIST_CODE;
   int err_total = 0, checks = 0, cyc = 0, i;
   mawm_top #(.LOCK_WARN_CYC(32'd20)) dut_u (.*);
   mawm_motor motor_u (.clock(CLOCK), .heat(heat), .jam(jam), .stop_open(ext_open), .speed_cmd(speed),
      .thermal_open(THERMAL_OPEN), .shaft_locked(SHAFT_LOCKED), .shaft_speed(SHAFT_SPEED),
      .ext_fault_n(EXTERNAL_FAULT_INPUT));
   initial forever #12.5 CLOCK = ~CLOCK;
   // Outputs are read at the edge, before that edge's updates land
   task automatic tick(input int n);
      repeat (n) @(posedge CLOCK);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cause(input int k, input logic on);
      case (k)
         0: heat <= on;
         1: speed <= on ? 12'd2301 : 12'd0;
         2: ext_open <= on;
         default: STORE_FAIL <= on;
      endcase
   endtask
   // Raise one cause, check the alarm, then remove the cause
   task automatic trip(input int k, input logic [7:0] code);
      cause(k, 1'b1);
      tick(6);
      chk(ALARM_CODE, code);
      chk({5'h0, ALARM_OUT, ALARM_LED, MOTOR_COAST}, 8'h03);
      cause(k, 1'b0);
      tick(4);
   endtask
   // One-cycle pulse on the clear input or the panel reset
   task automatic clr(input logic pnl);
      if (pnl) PANEL_RESET <= 1;
      else FAULT_CLEAR <= 1;
      tick(1);
      PANEL_RESET <= 0;
      FAULT_CLEAR <= 0;
      tick(5);
   endtask
   task automatic por(input logic en, input logic [7:0] code);
      SRST <= 1;
      FORWARD_RUN_INPUT <= 1;
      POWERON_ALARM_ENABLE <= en;
      tick(5);
      SRST <= 0;
      tick(5);
      chk(ALARM_CODE, code);
      FORWARD_RUN_INPUT <= 0;
      tick(5);
      chk(ALARM_OUT, 1);
   endtask
   // Hang guard: the whole sequence needs well under this many cycles
   always @(posedge CLOCK) begin
      if (++cyc > 4000) begin
         err_total++;
         end_sim();
      end
   end
   initial begin
      tick(5);
      SRST <= 0;
      tick(3);
      trip(3, 8'h41);
      clr(0);
      chk(ALARM_CODE, 8'h41);
      clr(1);
      chk(ALARM_OUT, 1);
      trip(0, 8'h25);
      FORWARD_RUN_INPUT <= 1;
      tick(1);
      FAULT_CLEAR <= 1;
      tick(2);
      FORWARD_RUN_INPUT <= 0;
      tick(5);
      chk(ALARM_OUT, 0);
      FAULT_CLEAR <= 0;
      tick(2);
      clr(0);
      chk(ALARM_OUT, 1);
      EXT_FAULT_ASSIGNED <= 0;
      ext_open <= 1;
      speed <= 12'd2200;
      tick(6);
      chk({ALARM_OUT, BRAKE_CURRENT}, 8'h03);
      ext_open <= 0;
      speed <= 12'd0;
      jam <= 1;
      // Sensor model lags a cycle; re-arm only once the contact reads closed
      tick(2);
      EXT_FAULT_ASSIGNED <= 1;
      tick(26);
      chk({CAUTION_OUTPUT, ALARM_OUT, CAUTION_TERMINAL}, 8'h06);
      chk(CAUTION_CODE, 8'h30);
      tick(25);
      chk(ALARM_CODE, 8'h28);
      jam <= 0;
      tick(5);
      chk(CAUTION_OUTPUT, 0);
      clr(0);
      // Operation error by terminal mapping, then by leaving test mode
      CAUTION_ASSIGNED <= 1;
      for (i = 0; i < 2; i++) begin
         FORWARD_RUN_INPUT <= !i[0];
         REVERSE_RUN_INPUT <= i[0];
         TEST_MODE <= i[0];
         INCHING_RUN <= i[0];
         RUN_MAP_TERM_ACTIVE <= !i[0];
         RUN_MAP_WRITE <= !i[0];
         tick(2);
         RUN_MAP_WRITE <= 0;
         TEST_MODE <= 0;
         tick(5);
         chk({CAUTION_OUTPUT, MOTOR_STOP, CAUTION_TERMINAL}, 8'h07);
         chk(CAUTION_CODE, 8'h6f);
         FORWARD_RUN_INPUT <= 0;
         REVERSE_RUN_INPUT <= 0;
         INCHING_RUN <= 0;
         tick(5);
         chk(CAUTION_OUTPUT, 0);
      end
      // Warning record clears on request while no warning is active
      CAUTION_CLEAR <= 1;
      tick(1);
      CAUTION_CLEAR <= 0;
      tick(2);
      chk(CAUTION_CODE, 8'h00);
      // Nine alarms fill the whole history, so no entry is left unknown
      for (i = 0; i < 9; i++) begin
         trip(i % 3, tab[i % 3]);
         clr(0);
      end
      for (i = 0; i < 9; i++) begin
         HIST_INDEX <= i[3:0];
         tick(4);
         chk(HIST_CODE, tab[(8 - i) % 3]);
      end
      por(1, 8'h45);
      por(0, 8'h00);
      POWERON_ALARM_ENABLE <= 1;
      HIST_CLEAR <= 1;
      tick(1);
      HIST_CLEAR <= 0;
      tick(4);
      chk(DISPLAY_BLINK, 1);
      end_sim();
   end
endmodule // tb
bind mawm_top mawm_checker #(.LOCK_WARN_CYC(LOCK_WARN_CYC)) chk_u (.*);
`default_nettype wire
